// *** src/pds_regs.svh ***
/*
 * Register offsets, field positions, reset values and cycle counts
 * of the powerdown sequencer. Assumes nothing; definitions only.
 */
`ifndef PDS_REGS_SVH
`define PDS_REGS_SVH

// ==========================================================
// Control register
// ==========================================================
`define PDS_CTRL_ADDR 14'h3FEF
`define PDS_CTRL_RESET 16'h0000
`define PDS_BIT_CRYSTAL_DRIVE_OFF 15
`define PDS_BIT_EXIT_DELAY_SELECT 14
`define PDS_BIT_FORCE_SLEEP 13
`define PDS_BIT_CONTEXT_CLEAR 12

// ==========================================================
// Program addresses and context values
// ==========================================================
`define PDS_NMI_VECTOR 14'h002C
`define PDS_RESET_VECTOR 14'h0000
`define PDS_STACK_STATE_INIT 8'h55

// ==========================================================
// Start-up counts, in input_clock cycles
// ==========================================================
`define PDS_QUICK_CYCLES 100
`define PDS_QUICK_MIN 100
`define PDS_QUICK_MAX 400
`define PDS_EXIT_DELAY_CYCLES 4096
`define PDS_BOOT_SAMPLE_WAIT 2

`endif

// *** src/pds_pkg.sv ***
/*
 * Types of the powerdown sequencer.
 * Assumes pds_regs.svh for the numeric constants.
 */
package pds_pkg;
  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0] {
    PDS_RUN,
    PDS_HANDLER,
    PDS_ENTER,
    PDS_DORMANT,
    PDS_WAKE
  } pds_state_e;
endpackage : pds_pkg

// *** src/pds_delay_timer.sv ***
/*
 * Down-counting start-up timer: loads a count on a start pulse and
 * pulses done once that many cycles have passed.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module pds_delay_timer #(
  parameter int W = 13
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_start,
  input wire logic [W-1:0] i_count,
  // Status
  output logic o_busy,
  output logic o_done
);

  // ==========================================================
  // Counter
  // ==========================================================
  logic [W-1:0] cnt_r;

  // Elaboration check: the done compare needs at least two bits
  if (W < 2) begin : g_bad_w
    $error("pds_delay_timer: W too small");
  end

  // Count down while busy
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      cnt_r <= i_count;
      o_busy <= (i_count != '0);
    end else if (o_busy) begin
      cnt_r <= cnt_r - W'(1);
      o_busy <= (cnt_r != W'(1));
    end
  end

  // Done pulse in the cycle after the last counted cycle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= o_busy && !i_start && (cnt_r == W'(1));
    end
  end

endmodule : pds_delay_timer

`default_nettype wire

// *** src/pds_sequencer.sv ***
/*
 * Powerdown sequencer of a DSP core: entry by pin or force bit,
 * non-maskable vector, dormant state on halt, exit by pin or reset.
 * Assumes the core reports halt and interrupt-return execution and
 * obeys the stall, vector and context-clear outputs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pds_regs.svh"

module pds_sequencer
  import pds_pkg::*;
#(
  parameter int QUICK_CYCLES = `PDS_QUICK_CYCLES,
  parameter int EXIT_DELAY_CYCLES = `PDS_EXIT_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Pins from outside
  input wire logic i_pwd_n,
  input wire logic [1:0] i_boot_mode,
  // Core data memory access to the control register
  input wire logic i_dm_wr,
  input wire logic i_dm_rd,
  input wire logic [13:0] i_dm_addr,
  input wire logic [15:0] i_dm_wdata,
  output logic [15:0] o_dm_rdata,
  // Core instruction events
  input wire logic i_idle_exec,
  input wire logic i_rti_exec,
  // Core control
  output logic o_nmi_req,
  output logic [13:0] o_fetch_addr,
  output logic o_resume,
  output logic o_ctx_clear,
  output logic [7:0] o_stack_state_init,
  output logic o_fetch_stall,
  output logic o_core_clk_en,
  output logic o_hold_outputs,
  output logic o_xtal_drive_en,
  output logic o_boot_load
);

  localparam int TW = 13;

  // Elaboration checks on the start-up counts
  if (QUICK_CYCLES < `PDS_QUICK_MIN || QUICK_CYCLES > `PDS_QUICK_MAX) begin : g_bad_quick
    $error("pds_sequencer: QUICK_CYCLES out of range");
  end
  if (QUICK_CYCLES + EXIT_DELAY_CYCLES >= (1 << TW)) begin : g_bad_count
    $error("pds_sequencer: start-up counts too large");
  end

  // ==========================================================
  // Pin synchronisers and edges
  // ==========================================================
  logic pwd_m_r, pwd_s_r, pwd_p_r;
  logic [1:0] boot_m_r, boot_s_r;
  logic pwd_fall, pwd_rise;

  // Two flip-flops on each pin, a third on the request pin for edge detection
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwd_m_r <= 1'b1;
      pwd_s_r <= 1'b1;
      pwd_p_r <= 1'b1;
      boot_m_r <= 2'h3;
      boot_s_r <= 2'h3;
    end else begin
      pwd_m_r <= i_pwd_n;
      pwd_s_r <= pwd_m_r;
      pwd_p_r <= pwd_s_r;
      boot_m_r <= i_boot_mode;
      boot_s_r <= boot_m_r;
    end
  end

  assign pwd_fall = pwd_p_r && !pwd_s_r;
  assign pwd_rise = !pwd_p_r && pwd_s_r;

  // ==========================================================
  // Control register
  // ==========================================================
  function automatic logic ctrl_hit(input logic [13:0] addr);
    return addr == `PDS_CTRL_ADDR;
  endfunction : ctrl_hit

  logic [15:0] ctrl_r;
  logic ctrl_wr, force_set, force_clr, req_lvl;
  pds_state_e state_r;

  assign ctrl_wr = i_dm_wr && ctrl_hit(i_dm_addr);
  assign force_set = ctrl_wr && i_dm_wdata[`PDS_BIT_FORCE_SLEEP];
  assign req_lvl = !pwd_s_r || ctrl_r[`PDS_BIT_FORCE_SLEEP];

  // Write storage; force bit cleared by hardware, a new set wins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_r <= `PDS_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= i_dm_wdata;
      end
      if (force_clr && !force_set) begin
        ctrl_r[`PDS_BIT_FORCE_SLEEP] <= 1'b0;
      end
    end
  end

  // Read data
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_dm_rdata <= 16'h0000;
    end else if (i_dm_rd) begin
      o_dm_rdata <= ctrl_hit(i_dm_addr) ? ctrl_r : 16'h0000;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  logic phase_r, enter_two_r, rise_seen_r;
  logic tmr_start, tmr_busy, tmr_done;
  logic [TW-1:0] tmr_count;
  logic enter_req, exit_req;

  assign enter_req = (state_r == PDS_HANDLER) && i_idle_exec && req_lvl;
  assign exit_req = (state_r == PDS_DORMANT) && (pwd_rise || rise_seen_r);
  assign force_clr = enter_req || ((state_r == PDS_HANDLER) && i_rti_exec);
  assign tmr_start = exit_req;
  // Quick period alone, or with the added delay
  assign tmr_count = ctrl_r[`PDS_BIT_EXIT_DELAY_SELECT] ?
                     TW'(QUICK_CYCLES + EXIT_DELAY_CYCLES) :
                     TW'(QUICK_CYCLES);

  // Internal clock phase, picks one or two entry cycles
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= !phase_r;
    end
  end

  // State transitions
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= PDS_RUN;
      enter_two_r <= 1'b0;
      rise_seen_r <= 1'b0;
    end else begin
      case (state_r)
        PDS_RUN: begin
          if (pwd_fall || force_set) state_r <= PDS_HANDLER;
        end
        PDS_HANDLER: begin
          if (enter_req) begin
            state_r <= PDS_ENTER;
            enter_two_r <= phase_r;
            rise_seen_r <= 1'b0;
          end else if (i_rti_exec) begin
            state_r <= PDS_RUN;
          end
        end
        PDS_ENTER: begin
          if (pwd_rise) rise_seen_r <= 1'b1;
          if (enter_two_r) enter_two_r <= 1'b0;
          else state_r <= PDS_DORMANT;
        end
        PDS_DORMANT: begin
          if (exit_req) begin
            state_r <= PDS_WAKE;
            rise_seen_r <= 1'b0;
          end
        end
        PDS_WAKE: begin
          // Cleared context restarts at the reset vector, outside the handler
          if (tmr_done) begin
            state_r <= ctrl_r[`PDS_BIT_CONTEXT_CLEAR] ? PDS_RUN : PDS_HANDLER;
          end
        end
        default: state_r <= PDS_RUN;
      endcase
    end
  end

  pds_delay_timer #(.W(TW)) u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(tmr_start),
    .i_count(tmr_count),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // ==========================================================
  // Core control outputs
  // ==========================================================
  logic wake_done;
  assign wake_done = (state_r == PDS_WAKE) && tmr_done;

  // Vector request, resume and context clear pulses
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nmi_req <= 1'b0;
      o_resume <= 1'b0;
      o_ctx_clear <= 1'b0;
      o_fetch_addr <= `PDS_RESET_VECTOR;
    end else begin
      o_nmi_req <= ((state_r == PDS_RUN) || (state_r == PDS_HANDLER)) &&
                   (pwd_fall || force_set);
      o_resume <= wake_done;
      o_ctx_clear <= wake_done && ctrl_r[`PDS_BIT_CONTEXT_CLEAR];
      if (((state_r == PDS_RUN) || (state_r == PDS_HANDLER)) && (pwd_fall || force_set)) begin
        o_fetch_addr <= `PDS_NMI_VECTOR;
      end else if (wake_done && ctrl_r[`PDS_BIT_CONTEXT_CLEAR]) begin
        o_fetch_addr <= `PDS_RESET_VECTOR;
      end
    end
  end

  assign o_stack_state_init = `PDS_STACK_STATE_INIT;
  assign o_core_clk_en = (state_r != PDS_DORMANT);
  assign o_hold_outputs = (state_r == PDS_DORMANT);
  assign o_fetch_stall = (state_r == PDS_DORMANT) || (state_r == PDS_WAKE);
  assign o_xtal_drive_en = !((state_r == PDS_DORMANT) &&
                             ctrl_r[`PDS_BIT_CRYSTAL_DRIVE_OFF]);

  // ==========================================================
  // Boot request after reset
  // ==========================================================
  logic [1:0] boot_wait_r;

  // Sample boot pins once both synchroniser stages hold pin values
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      boot_wait_r <= 2'h0;
      o_boot_load <= 1'b0;
    end else begin
      o_boot_load <= 1'b0;
      if (boot_wait_r != 2'h3) begin
        boot_wait_r <= boot_wait_r + 2'h1;
      end
      if (boot_wait_r == 2'(`PDS_BOOT_SAMPLE_WAIT)) begin
        o_boot_load <= (boot_s_r == 2'h0);
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence halt_seq;
    (state_r == PDS_HANDLER) && i_idle_exec && req_lvl;
  endsequence

  entry_time_a: assert property (halt_seq |-> ##[2:3] (state_r == PDS_DORMANT))
    else $error("dormant not reached in time");
  nmi_edge_a: assert property ((state_r == PDS_HANDLER) && pwd_fall |=> o_nmi_req)
    else $error("handler edge raised no vector");
  vector_addr_a: assert property (o_nmi_req |-> o_fetch_addr == 14'h002C)
    else $error("wrong handler vector");
  rti_abort_a: assert property ((state_r == PDS_HANDLER) && i_rti_exec && !enter_req
                                |=> state_r == PDS_RUN)
    else $error("return did not abandon sequence");
  clk_stop_a: assert property ((state_r == PDS_DORMANT) |-> !o_core_clk_en && o_fetch_stall)
    else $error("clocks run while dormant");
  quick_exit_a: assert property (exit_req && !ctrl_r[14] |-> ##[101:102] o_resume)
    else $error("quick start-up wrong length");
  long_stall_a: assert property (exit_req && ctrl_r[14] |=> o_fetch_stall [*8])
    else $error("delayed start-up ended early");
  ctx_clear_a: assert property (o_ctx_clear |-> o_resume && o_fetch_addr == 14'h0000)
    else $error("context clear without reset vector");
  xtal_off_a: assert property (o_hold_outputs && ctrl_r[15] |-> !o_xtal_drive_en)
    else $error("crystal driven while disabled");
  wake_busy_a: assert property ((state_r == PDS_WAKE) |-> tmr_busy || tmr_done)
    else $error("start-up timer idle during wake");

endmodule : pds_sequencer

`default_nettype wire

// *** tb/pds_pin_model.sv ***
/*
 * Model of the external controller: drives the powerdown request pin
 * and the reset line. Assumes the bench calls its tasks from one process.
 */
`timescale 1ns/10ps
`default_nettype none

module pds_pin_model (
  // Clock
  input wire logic i_clk,
  // Pins into the device
  output logic o_pwd_n,
  output logic o_sys_rst
);
  // ==========================================================
  // Idle levels
  // ==========================================================
  // Request released, reset asserted from time zero
  initial begin
    o_pwd_n = 1'h1;
    o_sys_rst = 1'h1;
  end

  // ==========================================================
  // Pin actions, launched at a clock edge
  // ==========================================================
  // Request assertion; used for every entry fall, and for a second fall inside a handler only when a test asks for it
  task automatic pin_fall();
    @(posedge i_clk);
    o_pwd_n <= 1'h0;
  endtask : pin_fall

  // Request release
  task automatic pin_rise();
    @(posedge i_clk);
    o_pwd_n <= 1'h1;
  endtask : pin_rise

  // Reset pulse; request released with it, clock kept running
  task automatic reset_pulse(input int cycles);
    @(posedge i_clk);
    o_sys_rst <= 1'h1;
    o_pwd_n <= 1'h1;
    repeat (cycles) @(posedge i_clk);
    o_sys_rst <= 1'h0;
  endtask : reset_pulse
endmodule : pds_pin_model

`default_nettype wire

// *** tb/dsp_powerdown_sequencer_tb.sv ***
/*
 * Self-checking bench of the powerdown sequencer.
 * Assumes pds_pin_model for the pins; shortened exit delay.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pds_regs.svh"

module dsp_powerdown_sequencer_tb;
  localparam int QUICK = 100;
  localparam int DELAY = 16;
  localparam logic [13:0] CTRL = `PDS_CTRL_ADDR;
  logic i_clk, i_sys_rst, i_pwd_n, i_dm_wr, i_dm_rd, i_idle_exec, i_rti_exec;
  logic [1:0] i_boot_mode;
  logic [13:0] i_dm_addr, o_fetch_addr;
  logic [15:0] i_dm_wdata, o_dm_rdata, rd;
  logic o_nmi_req, o_resume, o_ctx_clear, o_fetch_stall, o_core_clk_en;
  logic o_hold_outputs, o_xtal_drive_en, o_boot_load;
  logic [7:0] o_stack_state_init;
  int err_total = 0;
  int check_count = 0;
  int n;

  // ==========================================================
  // Clock, pins, design
  // ==========================================================
  // 10 MHz clock
  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  // External controller
  pds_pin_model pin_u (.i_clk(i_clk), .o_pwd_n(i_pwd_n), .o_sys_rst(i_sys_rst));

  // Device under test
  pds_sequencer #(.QUICK_CYCLES(QUICK), .EXIT_DELAY_CYCLES(DELAY)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pwd_n(i_pwd_n), .i_boot_mode(i_boot_mode),
    .i_dm_wr(i_dm_wr), .i_dm_rd(i_dm_rd), .i_dm_addr(i_dm_addr), .i_dm_wdata(i_dm_wdata),
    .o_dm_rdata(o_dm_rdata), .i_idle_exec(i_idle_exec), .i_rti_exec(i_rti_exec),
    .o_nmi_req(o_nmi_req), .o_fetch_addr(o_fetch_addr), .o_resume(o_resume),
    .o_ctx_clear(o_ctx_clear), .o_stack_state_init(o_stack_state_init),
    .o_fetch_stall(o_fetch_stall), .o_core_clk_en(o_core_clk_en),
    .o_hold_outputs(o_hold_outputs), .o_xtal_drive_en(o_xtal_drive_en),
    .o_boot_load(o_boot_load));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  // Comparison and verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Watched flags: 0 vector, 1 dormant, 2 resume, 3 boot
  function automatic logic flag(input int k);
    case (k)
      0: return o_nmi_req;
      1: return ~o_core_clk_en;
      2: return o_resume;
      default: return o_boot_load;
    endcase
  endfunction : flag

  // Bounded wait; n is edges taken, lim+1 when never seen
  task automatic wait_flag(input int k, input int lim, input bit must, output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (n < lim && flag(k) !== 1'h1);
    if (flag(k) !== 1'h1) begin
      n = lim + 1;
      if (must) begin
        err_total++;
        $display("mismatch wait_flag_%0d expected 1 seen 0", k);
        final_report();
      end
    end
  endtask : wait_flag

  // Core strobes, one cycle each
  task automatic reg_wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_dm_wr <= 1'h1;
    i_dm_addr <= a;
    i_dm_wdata <= d;
    @(posedge i_clk);
    i_dm_wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [13:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_dm_rd <= 1'h1;
    i_dm_addr <= a;
    @(posedge i_clk);
    i_dm_rd <= 1'h0;
    @(posedge i_clk);
    d = o_dm_rdata;
  endtask : reg_rd

  task automatic pulse(input bit is_rti);
    @(posedge i_clk);
    if (is_rti) i_rti_exec <= 1'h1;
    else i_idle_exec <= 1'h1;
    @(posedge i_clk);
    i_rti_exec <= 1'h0;
    i_idle_exec <= 1'h0;
  endtask : pulse

  // Request, vector, halt, dormant
  task automatic sleep();
    pin_u.pin_fall();
    wait_flag(0, 8, 1, n);
    check("vector", 16'(o_fetch_addr), 16'(`PDS_NMI_VECTOR));
    pulse(0);
    wait_flag(1, 5, 1, n);
    check("hold", 16'(o_hold_outputs), 16'h0001);
    check("stall", 16'(o_fetch_stall), 16'h0001);
  endtask : sleep

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_regs();
    reg_wr(CTRL, 16'hD5A5);
    reg_wr(14'h3FEE, 16'hFFFF);
    reg_rd(CTRL, rd);
    check("ctrl", rd, 16'hD5A5);
    reg_rd(14'h3FEE, rd);
    check("unmapped", rd, 16'h0000);
    reg_wr(CTRL, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_quick();
    sleep();
    check("xtal_on", 16'(o_xtal_drive_en), 16'h0001);
    repeat (20) @(posedge i_clk);
    check("still_dormant", 16'(o_core_clk_en), 16'h0000);
    check("held_addr", 16'(o_fetch_addr), 16'(`PDS_NMI_VECTOR));
    pin_u.pin_rise();
    wait_flag(2, 300, 1, n);
    check("quick_time", 16'(n >= QUICK && n <= QUICK + 8), 16'h0001);
    check("no_clear", 16'(o_ctx_clear), 16'h0000);
    @(posedge i_clk);
    check("resume_addr", 16'(o_fetch_addr), 16'(`PDS_NMI_VECTOR));
    check("clk_back", 16'(o_core_clk_en), 16'h0001);
    pulse(1);
    $display("test quick done");
  endtask : t_quick

  task automatic t_force_abort();
    reg_wr(CTRL, 16'h2000);
    wait_flag(0, 8, 1, n);
    check("force_vector", 16'(o_fetch_addr), 16'(`PDS_NMI_VECTOR));
    @(posedge i_clk);
    pin_u.pin_fall();
    wait_flag(0, 8, 1, n);
    pin_u.pin_rise();
    pulse(1);
    pulse(0);
    wait_flag(1, 4, 0, n);
    check("abandoned", 16'(n > 4), 16'h0001);
    reg_rd(CTRL, rd);
    check("force_clear", rd, 16'h0000);
    $display("test force_abort done");
  endtask : t_force_abort

  task automatic t_delay_clear();
    reg_wr(CTRL, 16'hD000);
    sleep();
    check("xtal_off", 16'(o_xtal_drive_en), 16'h0000);
    pin_u.pin_rise();
    wait_flag(2, 300, 1, n);
    check("slow_time", 16'(n >= QUICK + DELAY && n <= QUICK + DELAY + 8), 16'h0001);
    check("clear", 16'(o_ctx_clear), 16'h0001);
    check("stack_state", 16'(o_stack_state_init), 16'h0055);
    check("clear_addr", 16'(o_fetch_addr), 16'h0000);
    $display("test delay_clear done");
  endtask : t_delay_clear

  task automatic t_reset_exit();
    i_boot_mode <= 2'h2;
    sleep();
    pin_u.reset_pulse(5);
    wait_flag(3, 4, 0, n);
    check("no_boot", 16'(n > 4), 16'h0001);
    check("rst_addr", 16'(o_fetch_addr), 16'h0000);
    check("rst_stall", 16'(o_fetch_stall), 16'h0000);
    check("rst_clk", 16'(o_core_clk_en), 16'h0001);
    reg_rd(CTRL, rd);
    check("rst_ctrl", rd, 16'h0000);
    $display("test reset_exit done");
  endtask : t_reset_exit

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    i_boot_mode = 2'h0;
    i_dm_wr = 1'h0;
    i_dm_rd = 1'h0;
    i_dm_addr = 14'h0000;
    i_dm_wdata = 16'h0000;
    i_idle_exec = 1'h0;
    i_rti_exec = 1'h0;
    pin_u.reset_pulse(10);
    wait_flag(3, 4, 1, n);
    check("boot_addr", 16'(o_fetch_addr), 16'h0000);
    t_regs();
    t_quick();
    t_force_abort();
    t_delay_clear();
    t_reset_exit();
    final_report();
  end
endmodule : dsp_powerdown_sequencer_tb

`default_nettype wire
